// ===== verilog/gmc_regs.sv
`timescale 1ns/1ps
// Behaviour
// R01: velocity field indexes ramp table, 1 to 225
// R02: written limit holds until next velocity command
// R03: index above table top clamps to top
// R04: faster than limit requests ramp down
// R05: D8 applies gauge 0, D9 gauge 1
// R06: host sends D12:D10 zero in velocity
// R07: 12-bit targets at addresses 010 and 011
// R08: host sends D12 zero in position
// R09: one target count equals one microstep
// R10: zeroing moves full steps, one coil driven
// R11: zeroing integrates back-EMF of undriven coil
// R12: D1 starts or cancels, D0 picks gauge
// R13: host sends D12:D5 and D3 zero
// R14: D4 zero: stall stops zeroing automatically
// R15: D4 one: only a stop command halts
// R16: D2 sets integrator sequence direction
// R17: zeroing always heads to home side
// R18: 16-bit word, acts on chip select release
// R19: bad must-be-zero bits drop whole command
module gmc_regs #(
   parameter logic [7:0] VEL_TABLE_MAX = gmc_pkg::VEL_INDEX_TOP
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Serial command pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   // Motion engine feedback, per gauge
   input wire logic [1:0][7:0] speed_index,
   input wire logic [1:0] stall_detected,
   input wire logic [1:0] home_side_select,
   // Command state, per gauge
   output gmc_pkg::gmc_gauge_t [1:0] gauge_state,
   // Serial status
   output logic cmd_accepted,
   output logic cmd_rejected
);
   import gmc_pkg::*;

   // Pin synchronisers
   logic [1:0] cs_sync;
   logic [1:0] sclk_sync;
   logic [1:0] si_sync;
   // Edge detector history
   logic cs_last;
   logic sclk_last;
   logic [15:0] shift_word;
   logic [4:0] bit_count;
   logic [15:0] next_shift_word;
   logic [4:0] next_bit_count;
   logic next_cmd_accepted;
   logic next_cmd_rejected;

   // Decoded command, valid for one cycle on chip select release
   logic sclk_rise;
   logic cs_release;
   logic word_take;
   logic [2:0] cmd_addr;
   logic [12:0] cmd_data;
   logic vel_write;
   logic pos_write;
   logic rtz_write;
   logic cmd_known;
   logic [7:0] vel_clamped;

   // Next command state, one entry per gauge
   gmc_gauge_t next_gauge [2];

   // Two-flop synchronisers, idle levels after reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cs_sync <= 2'h3;
         sclk_sync <= 2'h0;
         si_sync <= 2'h0;
      end else begin
         cs_sync <= {cs_sync[0], cs_n};
         sclk_sync <= {sclk_sync[0], sclk};
         si_sync <= {si_sync[0], si};
      end
   end

   // Edge detection on synchronised pins
   assign sclk_rise = sclk_sync[1] & ~sclk_last;
   assign cs_release = cs_sync[1] & ~cs_last;
   // Exactly sixteen sclk rises, so a glitch cannot land a half word
   assign word_take = cs_release && (bit_count == WORD_COUNT); // R18

   // Fields of the received word
   assign cmd_addr = shift_word[ADDR_MSB:ADDR_LSB];
   assign cmd_data = shift_word[DATA_BITS-1:0];

   // Must-be-zero checks per register
   always_comb begin
      vel_write = 1'b0;
      pos_write = 1'b0;
      rtz_write = 1'b0;
      cmd_known = 1'b1;
      unique case (cmd_addr)
         ADDR_MAX_VELOCITY_LIMIT: begin
            vel_write = word_take && (cmd_data[VEL_ZERO_MSB:VEL_ZERO_LSB] == 3'h0); // R19
         end
         ADDR_GAUGE0_TARGET_POSITION, ADDR_GAUGE1_TARGET_POSITION: begin
            pos_write = word_take && !cmd_data[POS_ZERO_BIT]; // R19
         end
         ADDR_RETURN_TO_ZERO_COMMAND: begin
            rtz_write = word_take && (cmd_data[RTZ_ZERO_MSB:RTZ_ZERO_LSB] == 8'h00)
               && !cmd_data[RTZ_ZERO_LOW_BIT]; // R19
         end
         default: begin
            cmd_known = 1'b0;
         end
      endcase
   end

   // Velocity index clamped into the ramp table
   // Index 0 has no table entry, so it is raised to the first one
   always_comb begin
      vel_clamped = cmd_data[VEL_INDEX_MSB:0]; // R01
      if (vel_clamped > VEL_TABLE_MAX) begin
         vel_clamped = VEL_TABLE_MAX; // R03
      end else if (vel_clamped < VEL_INDEX_MIN) begin
         vel_clamped = VEL_INDEX_MIN;
      end
   end

   // Shift register next state, MSB first on sclk rise
   always_comb begin
      next_shift_word = shift_word;
      next_bit_count = bit_count;
      next_cmd_accepted = 1'b0;
      next_cmd_rejected = 1'b0;
      // Chip select high clears the count between words
      if (cs_sync[1]) begin
         next_bit_count = COUNT_RST;
      end else if (sclk_rise) begin
         next_shift_word = {shift_word[WORD_BITS-2:0], si_sync[1]};
         // Saturate so a long frame cannot wrap back to sixteen
         if (bit_count != 5'h1F) begin
            next_bit_count = bit_count + 5'h01;
         end
      end
      // Unknown addresses pass silently, wrong lengths always refuse
      if (cs_release) begin
         next_cmd_accepted = vel_write | pos_write | rtz_write;
         next_cmd_rejected = (cmd_known && word_take && !(vel_write | pos_write | rtz_write))
            || (bit_count != WORD_COUNT);
      end
   end

   // Receiver registers, pulses last one cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cs_last <= 1'b1;
         sclk_last <= 1'b0;
         shift_word <= SHIFT_RST;
         bit_count <= COUNT_RST;
         cmd_accepted <= 1'b0;
         cmd_rejected <= 1'b0;
      end else begin
         cs_last <= cs_sync[1];
         sclk_last <= sclk_sync[1];
         shift_word <= next_shift_word;
         bit_count <= next_bit_count;
         cmd_accepted <= next_cmd_accepted;
         cmd_rejected <= next_cmd_rejected;
      end
   end

   // Per-gauge command state
   // Both gauges share the decode, each keeps its own fields
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gauge
         gmc_gauge_t next_state;
         logic vel_hit;
         logic pos_hit;
         logic rtz_hit;

         // Command strobes aimed at this gauge
         assign vel_hit = vel_write && cmd_data[VEL_APPLY_G0_BIT + g]; // R05
         assign pos_hit = pos_write && (cmd_addr == (ADDR_GAUGE0_TARGET_POSITION + 3'(g))); // R07
         assign rtz_hit = rtz_write && (cmd_data[RTZ_SELECT_BIT] == 1'(g)); // R12

         // Next state, a command for this gauge wins over a stall
         always_comb begin
            next_state = gauge_state[g];
            if (vel_hit) begin
               next_state.vel_limit = vel_clamped; // R02
            end
            if (pos_hit) begin
               next_state.target = cmd_data[POS_MSB:0]; // R09
            end
            // Zeroing fields follow a command for this gauge, and a stall clears rtz_run in automatic mode
            if (rtz_hit) begin
               next_state.rtz_run = cmd_data[RTZ_GO_BIT]; // R12
               next_state.rtz_uncond = cmd_data[RTZ_UNCOND_BIT]; // R15
               next_state.rtz_cw_seq = cmd_data[RTZ_DIR_BIT]; // R16
            end else if (gauge_state[g].rtz_run && !gauge_state[g].rtz_uncond
                  && stall_detected[g]) begin
               next_state.rtz_run = 1'b0; // R14
            end
            // Full-step single-coil drive and integration follow rtz_run
            next_state.rtz_home_cw = home_side_select[g]; // R17
            // Against the limit being stored, so a lower limit acts at once
            next_state.ramp_down = speed_index[g] > next_state.vel_limit; // R04
         end

         assign next_gauge[g] = next_state;
      end
   endgenerate

   // Command state register for both gauges
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gauge_state <= {GAUGE_RST, GAUGE_RST};
      end else begin
         gauge_state <= {next_gauge[1], next_gauge[0]}; // R10 R11
      end
   end
endmodule

// ===== verilog/gmc_pkg.sv
package gmc_pkg;
   // Serial word layout: 3-bit address above 13 data bits
   localparam int WORD_BITS = 16;
   localparam int DATA_BITS = 13;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 13;
   localparam logic [4:0] WORD_COUNT = 5'h10;
   localparam logic [4:0] COUNT_RST = 5'h00;

   // Register addresses
   localparam logic [2:0] ADDR_MAX_VELOCITY_LIMIT = 3'h1;
   localparam logic [2:0] ADDR_GAUGE0_TARGET_POSITION = 3'h2;
   localparam logic [2:0] ADDR_GAUGE1_TARGET_POSITION = 3'h3;
   localparam logic [2:0] ADDR_RETURN_TO_ZERO_COMMAND = 3'h4;

   // Velocity command fields
   localparam int VEL_INDEX_MSB = 7;
   localparam int VEL_APPLY_G0_BIT = 8;
   localparam int VEL_APPLY_G1_BIT = 9;
   localparam int VEL_ZERO_MSB = 12;
   localparam int VEL_ZERO_LSB = 10;
   localparam logic [7:0] VEL_INDEX_MIN = 8'h01;
   localparam logic [7:0] VEL_INDEX_TOP = 8'hE1;

   // Position command fields
   localparam int POS_MSB = 11;
   localparam int POS_ZERO_BIT = 12;

   // Return-to-zero command fields
   localparam int RTZ_SELECT_BIT = 0;
   localparam int RTZ_GO_BIT = 1;
   localparam int RTZ_DIR_BIT = 2;
   localparam int RTZ_ZERO_LOW_BIT = 3;
   localparam int RTZ_UNCOND_BIT = 4;
   localparam int RTZ_ZERO_MSB = 12;
   localparam int RTZ_ZERO_LSB = 5;

   // Values after reset
   localparam logic [7:0] VEL_LIMIT_RST = 8'hE1;
   localparam logic [11:0] TARGET_RST = 12'h000;
   localparam logic [15:0] SHIFT_RST = 16'h0000;

   // Per-gauge command state seen by the motion logic
   typedef struct packed {
      logic [7:0] vel_limit;
      logic [11:0] target;
      logic rtz_run;
      logic rtz_uncond;
      logic rtz_cw_seq;
      logic rtz_home_cw;
      logic ramp_down;
   } gmc_gauge_t;

   localparam gmc_gauge_t GAUGE_RST = '{
      vel_limit: VEL_LIMIT_RST,
      target: TARGET_RST,
      rtz_run: 1'b0,
      rtz_uncond: 1'b0,
      rtz_cw_seq: 1'b0,
      rtz_home_cw: 1'b0,
      ramp_down: 1'b0
   };
endpackage

// ===== dv/gmc_regs_asserts.sv
`timescale 1ns/1ps
module gmc_regs_asserts #(
   parameter logic [7:0] VEL_TABLE_MAX = gmc_pkg::VEL_INDEX_TOP
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic [1:0][7:0] speed_index,
   input wire logic [1:0] stall_detected,
   input wire logic [1:0] home_side_select,
   input wire gmc_pkg::gmc_gauge_t [1:0] gauge_state,
   input wire logic cmd_accepted,
   input wire logic cmd_rejected
);
   import gmc_pkg::*;
   gmc_gauge_t a, b;
   // Per-gauge views
   assign a = gauge_state[0];
   assign b = gauge_state[1];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Automatic run on gauge 0 meets a stall
   sequence auto_stall_s;
      a.rtz_run && !a.rtz_uncond && stall_detected[0];
   endsequence
   accept_once_a: assert property (cmd_accepted |=> !cmd_accepted)
      else $error("accept");
   reject_keep_a: assert property (cmd_rejected |-> $stable({a.target, b.target}))
      else $error("reject");
   target_why_a: assert property (!$stable({a.target, b.target}) |-> cmd_accepted)
      else $error("target");
   limit_range_a: assert property (a.vel_limit inside {[8'h01:VEL_TABLE_MAX]})
      else $error("limit");
   ramp_track_a: assert property ($stable(a.vel_limit) && !$past(sys_rst) |->
      a.ramp_down == ($past(speed_index[0]) > a.vel_limit)) else $error("ramp");
   home_copy_a: assert property (!$past(sys_rst) |->
      {b.rtz_home_cw, a.rtz_home_cw} == $past(home_side_select)) else $error("home");
   auto_stop_a: assert property (auto_stall_s |=> !a.rtz_run || cmd_accepted)
      else $error("stop");
   uncond_run_a: assert property (b.rtz_run && b.rtz_uncond |=> b.rtz_run || cmd_accepted)
      else $error("run");
   limit_hold_a: assert property (!$stable({a.vel_limit, b.vel_limit}) |-> cmd_accepted)
      else $error("limit change");
endmodule
bind gmc_regs gmc_regs_asserts #(.VEL_TABLE_MAX(VEL_TABLE_MAX)) chk_u (.mclk, .sys_rst,
   .speed_index, .stall_detected, .home_side_select, .gauge_state, .cmd_accepted, .cmd_rejected);

// ===== dv/gmc_host.sv
`timescale 1ns/1ps
module gmc_host (
   // Clock
   input wire logic mclk,
   // Serial pins
   output logic cs_n = 1'b1,
   output logic sclk = 1'b0,
   output logic si = 1'b0
);
   // Frame MSB first, optional stray bit, half period h
   task automatic send(input logic [15:0] w, input logic x, input int h);
      logic [16:0] f;
      f = {w, 1'b0};
      @(negedge mclk) cs_n = 1'b0;
      repeat (2) @(negedge mclk);
      for (int i = 16; i >= 1 - int'(x); i--) begin
         si = f[i];
         repeat (h) @(negedge mclk);
         sclk = 1'b1;
         repeat (h) @(negedge mclk);
         sclk = 1'b0;
      end
      repeat (h) @(negedge mclk);
      cs_n = 1'b1;
      si = ~si; // No stale bit left
      repeat (3) @(negedge mclk); // Return while the answer pulse stands
   endtask
endmodule

// ===== dv/gmc_regs_tb.sv
`timescale 1ns/1ps
module gmc_regs_tb;
   import gmc_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, cs_n, sclk, si, cmd_accepted, cmd_rejected;
   logic [1:0] stall_detected = 2'h0, run = 2'h0, s;
   logic [31:0] rng = 32'h28B8, spd = 32'h28B8;
   logic [7:0] v;
   logic [7:0] lim [2] = '{VEL_LIMIT_RST, VEL_LIMIT_RST};
   logic [11:0] tgt [2] = '{TARGET_RST, TARGET_RST};
   gmc_gauge_t [1:0] gauge_state;
   int bad_count = 0, checks = 0;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Expected limit for a written index
   function automatic logic [7:0] clamp(input logic [7:0] i);
      return (i == 8'h00) ? VEL_INDEX_MIN : (i > VEL_INDEX_TOP) ? VEL_INDEX_TOP : i;
   endfunction
   // Clock and random motion feedback
   always #20 mclk = ~mclk;
   always @(negedge mclk) spd = xs(spd);
   gmc_host host_u (.mclk, .cs_n, .sclk, .si);
   gmc_regs dut_u (.mclk, .sys_rst, .cs_n, .sclk, .si, .speed_index(spd[15:0]), .stall_detected,
      .home_side_select(spd[17:16]), .gauge_state, .cmd_accepted, .cmd_rejected);
   task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cmp;
      gmc_gauge_t q;
      for (int g = 0; g < 2; g++) begin
         q = gauge_state[g];
         chk({q.vel_limit, q.target, q.rtz_run}, {lim[g], tgt[g], run[g]});
      end
   endtask
   // One frame, then pulses and state
   task automatic cmd(input logic [15:0] w, input logic x, input logic [1:0] ar);
      host_u.send(w, x, 3 + int'(rng[0]));
      chk(21'({cmd_accepted, cmd_rejected}), 21'(ar));
      cmp();
   endtask
   // Stall flag for one cycle
   task automatic stall(input logic [1:0] m);
      @(negedge mclk) stall_detected = m;
      @(negedge mclk) stall_detected = 2'h0;
      repeat (2) @(negedge mclk);
      cmp();
   endtask
   task automatic print_verdict;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Reset, limits, targets, refusals, zeroing
   initial begin
      repeat (5) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (3) @(negedge mclk);
      cmp();
      for (int i = 0; i < 8; i++) begin
         rng = xs(rng);
         v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rng[7:0];
         s = (i < 2) ? 2'h3 : rng[9:8];
         if (s[0]) lim[0] = clamp(v);
         if (s[1]) lim[1] = clamp(v);
         cmd({3'h1, 3'h0, s, v}, 1'b0, 2'h2);
      end
      cmd(16'h2705, 1'b0, 2'h1);
      for (int i = 0; i < 4; i++) begin
         rng = xs(rng);
         tgt[i[0]] = (i < 2) ? 12'hFFF : rng[11:0];
         cmd({2'h1, i[0], 1'b0, tgt[i[0]]}, 1'b0, 2'h2);
      end
      cmd(16'h7ABC, 1'b0, 2'h1);
      cmd(16'h4055, 1'b1, 2'h1);
      for (int a = 5; a < 9; a++) cmd({3'(a), 13'h0FFF}, 1'b0, 2'h0);
      run = 2'h2;
      cmd(16'h8017, 1'b0, 2'h2);
      chk(21'({gauge_state[1].rtz_uncond, gauge_state[1].rtz_cw_seq}), 21'h3);
      stall(2'h2);
      run = 2'h3;
      cmd(16'h8002, 1'b0, 2'h2);
      run = 2'h2;
      stall(2'h1);
      cmd(16'h800B, 1'b0, 2'h1);
      run = 2'h0;
      cmd(16'h8001, 1'b0, 2'h2);
      print_verdict();
   end
endmodule
